/* rtl/gtwo_pkg.sv */
/*
 * Shared constants for the group 2 slave messaging block.
 * Assumes a 200 MHz core clock and a CAN controller around the block.
 */
package gtwo_pkg;
	localparam int          CLK_HZ           = 200_000_000;
	localparam int          RATE_125K_BPS    = 125_000;
	localparam int          RATE_250K_BPS    = 250_000;
	localparam int          RATE_500K_BPS    = 500_000;
	localparam logic [10:0] DIV_125K         = 11'(CLK_HZ / RATE_125K_BPS);
	localparam logic [10:0] DIV_250K         = 11'(CLK_HZ / RATE_250K_BPS);
	localparam logic [10:0] DIV_500K         = 11'(CLK_HZ / RATE_500K_BPS);
	localparam logic [1:0]  RATE_SEL_125K    = 2'h0;
	localparam logic [1:0]  RATE_SEL_250K    = 2'h1;
	localparam logic [2:0]  STUFF_RUN        = 3'h5;
	localparam logic [15:0] MSG_MAX_BYTES    = 16'hFFFF;
	localparam logic [3:0]  FRAME_BYTES      = 4'h8;
	localparam logic [1:0]  FRAG_FIRST       = 2'h0;
	localparam logic [1:0]  FRAG_MIDDLE      = 2'h1;
	localparam logic [1:0]  FRAG_LAST        = 2'h2;
	localparam logic [7:0]  SVC_ALLOCATE     = 8'h4B;
	localparam logic [7:0]  SVC_RELEASE      = 8'h4C;
	localparam logic [7:0]  SVC_ERROR_RSP    = 8'h94;
	localparam logic [7:0]  SVC_RSP_FLAG     = 8'h80;
	localparam logic [7:0]  GEN_ERR_CODE     = 8'h02;
	localparam logic [7:0]  ADD_ERR_CODE     = 8'h03;
	localparam logic [1:0]  GROUP2_TAG       = 2'h2;
	localparam logic [2:0]  MSG_ID_UNCONN    = 3'h3;
	localparam logic [7:0]  CONN_INST_COS    = 8'h04;
	localparam int          CHOICE_POLL_BIT  = 1;
	localparam int          CHOICE_COS_BIT   = 4;
	localparam int          CHOICE_CYC_BIT   = 5;
	localparam int          CHOICE_ACKS_BIT  = 6;
	localparam int          TRIG_CYCLES_DEF  = 2_000_000;
	localparam int          FIFO_WIDTH       = 9;
	localparam int          FIFO_DEPTH       = 32;
	typedef enum logic [3:0] {
		PR_IDLE    = 4'h1,
		PR_COLLECT = 4'h2,
		PR_SEND    = 4'h4,
		PR_ACK     = 4'h8
	} gtwo_prod_type;
endpackage : gtwo_pkg

/* rtl/gtwo_fifo.sv */
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; both ready and valid outputs are registered.
 */
`timescale 1ns/100ps
module gtwo_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input  wire logic             core_clk_i,
	input  wire logic             srst_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0]      cnt_reg, cnt_next;
	logic             push, pop;

	always_comb begin
		push     = in_valid_i && in_ready_o;
		pop      = out_valid_o && out_ready_i;
		wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
		rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
		cnt_next = cnt_reg;
		if (push && !pop) begin
			cnt_next = (AW+1)'(cnt_reg + 1'b1);
		end else if (pop && !push) begin
			cnt_next = (AW+1)'(cnt_reg - 1'b1);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data_i;
		end
		if (srst_i) begin
			wr_reg      <= '0;
			rd_reg      <= '0;
			cnt_reg     <= '0;
			in_ready_o  <= 1'b0;
			out_valid_o <= 1'b0;
		end else begin
			wr_reg      <= wr_next;
			rd_reg      <= rd_next;
			cnt_reg     <= cnt_next;
			in_ready_o  <= cnt_next < (AW+1)'(DEPTH);
			out_valid_o <= cnt_next != '0;
		end
	end

	// Head word read from the array; valid only follows a settled write
	assign out_data_o = mem_reg[rd_reg];
endmodule : gtwo_fifo

/* rtl/gtwo_slave.sv */
/*
 * Group 2 only slave: explicit request handling, change-of-state/cyclic
 * production with fragmentation, idle/run events and link bit timing.
 * Assumes a CAN controller that frames, arbitrates and checks messages.
 */
`timescale 1ns/100ps
module gtwo_slave
	import gtwo_pkg::*;
#(
	parameter int TRIG_CYCLES = TRIG_CYCLES_DEF
) (
	input  wire logic        core_clk_i,
	input  wire logic        srst_i,
	input  wire logic [5:0]  mac_id_i,
	input  wire logic [1:0]  rate_sel_i,
	input  wire logic [7:0]  app_data_i,
	input  wire logic        app_last_i,
	input  wire logic        app_valid_i,
	output logic             app_ready_o,
	input  wire logic        change_i,
	input  wire logic        req_valid_i,
	input  wire logic [7:0]  req_hdr_i,
	input  wire logic [7:0]  req_service_i,
	input  wire logic [7:0]  req_choice_i,
	output logic             rsp_valid_o,
	output logic [10:0]      rsp_id_o,
	output logic [31:0]      rsp_data_o,
	output logic [2:0]       rsp_len_o,
	output logic [7:0]       alloc_o,
	input  wire logic        ack_valid_i,
	input  wire logic        rx_cos_valid_i,
	input  wire logic [15:0] rx_cos_len_i,
	output logic             idle_evt_o,
	output logic             run_evt_o,
	output logic             tx_valid_o,
	input  wire logic        tx_ready_i,
	output logic [63:0]      tx_data_o,
	output logic [3:0]       tx_len_o,
	output logic [7:0]       tx_inst_o,
	output logic             bit_tick_o,
	input  wire logic        st_bit_i,
	input  wire logic        st_valid_i,
	output logic             st_ready_o,
	output logic             can_tx_o
);
	logic [7:0]  ff_data;
	logic        ff_last, ff_valid, ff_pop;
	gtwo_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk_i  (core_clk_i),
		.srst_i      (srst_i),
		.in_data_i   ({app_last_i, app_data_i}),
		.in_valid_i  (app_valid_i),
		.in_ready_o  (app_ready_o),
		.out_data_o  ({ff_last, ff_data}),
		.out_valid_o (ff_valid),
		.out_ready_i (ff_pop)
	);
	// Explicit path and connection state
	logic [7:0]  alloc_next;
	logic        rsp_valid_next, idle_next, run_next;
	logic [10:0] rsp_id_next;
	logic [31:0] rsp_data_next;
	logic [2:0]  rsp_len_next;
	logic        cos_on, ack_sup;
	always_comb begin
		alloc_next     = alloc_o;
		rsp_valid_next = 1'b0;
		rsp_id_next    = rsp_id_o;
		rsp_data_next  = rsp_data_o;
		rsp_len_next   = rsp_len_o;
		idle_next      = 1'b0;
		run_next       = 1'b0;
		if (req_valid_i) begin
			rsp_valid_next = 1'b1;
			rsp_id_next    = {GROUP2_TAG, mac_id_i, MSG_ID_UNCONN};
			case (req_service_i)
				SVC_ALLOCATE: begin
					alloc_next    = alloc_o | req_choice_i;
					rsp_data_next = {16'h0000, SVC_ALLOCATE | SVC_RSP_FLAG, req_hdr_i};
					rsp_len_next  = 3'h3;
				end
				SVC_RELEASE: begin
					alloc_next    = alloc_o & ~req_choice_i;
					rsp_data_next = {16'h0000, SVC_RELEASE | SVC_RSP_FLAG, req_hdr_i};
					rsp_len_next  = 3'h2;
				end
				default: begin
					rsp_data_next = {ADD_ERR_CODE, GEN_ERR_CODE, SVC_ERROR_RSP, req_hdr_i};
					rsp_len_next  = 3'h4;
				end
			endcase
		end
		if (rx_cos_valid_i && cos_on) begin
			idle_next = rx_cos_len_i == 16'h0000;
			run_next  = rx_cos_len_i != 16'h0000;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			alloc_o     <= 8'h00;
			rsp_valid_o <= 1'b0;
			rsp_id_o    <= 11'h000;
			rsp_data_o  <= 32'h0000_0000;
			rsp_len_o   <= 3'h0;
			idle_evt_o  <= 1'b0;
			run_evt_o   <= 1'b0;
		end else begin
			alloc_o     <= alloc_next;
			rsp_valid_o <= rsp_valid_next;
			rsp_id_o    <= rsp_id_next;
			rsp_data_o  <= rsp_data_next;
			rsp_len_o   <= rsp_len_next;
			idle_evt_o  <= idle_next;
			run_evt_o   <= run_next;
		end
	end
	assign cos_on  = alloc_o[CHOICE_COS_BIT] | alloc_o[CHOICE_CYC_BIT];
	assign ack_sup = alloc_o[CHOICE_ACKS_BIT];
	// Producer on connection instance 4
	gtwo_prod_type st_reg, st_next;
	logic [31:0] tmr_reg, tmr_next;
	logic        pend_reg, pend_next, frag_reg, frag_next;
	logic        end_reg, end_next;
	logic [3:0]  cnt_reg, cnt_next;
	logic [5:0]  fcnt_reg, fcnt_next;
	logic [15:0] tot_reg, tot_next;
	logic [63:0] frm_next;
	logic        tx_valid_next, last_byte;
	always_comb begin
		st_next       = st_reg;
		tmr_next      = tmr_reg;
		pend_next     = pend_reg | change_i;
		frag_next     = frag_reg;
		end_next      = end_reg;
		cnt_next      = cnt_reg;
		fcnt_next     = fcnt_reg;
		tot_next      = tot_reg;
		frm_next      = tx_data_o;
		tx_valid_next = tx_valid_o;
		ff_pop        = 1'b0;
		// Byte 65535 forcibly closes the message; the rest starts a new one
		last_byte     = ff_last || tot_reg == MSG_MAX_BYTES - 16'h0001;
		if (tmr_reg == 32'(TRIG_CYCLES - 1)) begin
			pend_next = 1'b1;
			tmr_next  = 32'h0;
		end else begin
			tmr_next  = tmr_reg + 32'h1;
		end
		case (st_reg)
			PR_IDLE: begin
				if (cos_on && pend_reg && ff_valid) begin
					pend_next  = change_i;
					tmr_next   = 32'h0;
					frag_next  = 1'b0;
					cnt_next   = 4'h0;
					fcnt_next  = 6'h00;
					tot_next   = 16'h0000;
					frm_next   = 64'h0;
					st_next    = PR_COLLECT;
				end
			end
			PR_COLLECT: begin
				if (ff_valid) begin
					if (!frag_reg && cnt_reg == 4'h7 && !last_byte) begin
						frag_next = 1'b1;
						end_next  = 1'b0;
						frm_next  = {tx_data_o[55:0], FRAG_FIRST, fcnt_reg};
						cnt_next  = FRAME_BYTES;
						st_next   = PR_SEND;
					end else begin
						ff_pop   = 1'b1;
						tot_next = tot_reg + 16'h0001;
						frm_next[cnt_reg[2:0]*8 +: 8] = ff_data;
						cnt_next = cnt_reg + 4'h1;
						end_next = last_byte;
						if (last_byte || cnt_reg == 4'h7) begin
							st_next = PR_SEND;
							if (frag_reg) begin
								frm_next[7:0] = {last_byte ? FRAG_LAST : FRAG_MIDDLE, fcnt_reg};
							end
						end
					end
				end
			end
			PR_SEND: begin
				tx_valid_next = 1'b1;
				if (tx_valid_o && tx_ready_i) begin
					tx_valid_next = 1'b0;
					fcnt_next     = fcnt_reg + 6'h01;
					cnt_next      = frag_reg ? 4'h1 : 4'h0;
					frm_next      = 64'h0;
					if (!frag_reg || end_reg) begin
						st_next = ack_sup ? PR_IDLE : PR_ACK;
					end else begin
						st_next = PR_COLLECT;
					end
				end
			end
			PR_ACK: begin
				// Next production waits for the master's acknowledgement
				if (ack_valid_i || !cos_on) begin
					st_next = PR_IDLE;
				end
			end
			default: st_next = PR_IDLE;
		endcase
	end
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			st_reg     <= PR_IDLE;
			tmr_reg    <= 32'h0;
			pend_reg   <= 1'b0;
			frag_reg   <= 1'b0;
			end_reg    <= 1'b0;
			cnt_reg    <= 4'h0;
			fcnt_reg   <= 6'h00;
			tot_reg    <= 16'h0000;
			tx_data_o  <= 64'h0;
			tx_valid_o <= 1'b0;
			tx_len_o   <= 4'h0;
			tx_inst_o  <= CONN_INST_COS;
		end else begin
			st_reg     <= st_next;
			tmr_reg    <= tmr_next;
			pend_reg   <= pend_next;
			frag_reg   <= frag_next;
			end_reg    <= end_next;
			cnt_reg    <= cnt_next;
			fcnt_reg   <= fcnt_next;
			tot_reg    <= tot_next;
			tx_data_o  <= frm_next;
			tx_valid_o <= tx_valid_next;
			tx_len_o   <= (st_reg == PR_COLLECT) ? cnt_next : tx_len_o;
			tx_inst_o  <= CONN_INST_COS;
		end
	end
	// Bit timing and stuffing
	logic [10:0] div_reg, div_next, div_max;
	logic [2:0]  run_reg, run_next_c;
	logic        tick_next, tx_next, rdy_next;
	always_comb begin
		case (rate_sel_i)
			RATE_SEL_125K: div_max = DIV_125K;
			RATE_SEL_250K: div_max = DIV_250K;
			default:       div_max = DIV_500K;
		endcase
		tick_next  = div_reg >= div_max - 11'h001;
		div_next   = tick_next ? 11'h000 : div_reg + 11'h001;
		tx_next    = can_tx_o;
		run_next_c = run_reg;
		rdy_next   = 1'b0;
		if (tick_next) begin
			if (run_reg == STUFF_RUN) begin
				tx_next    = ~can_tx_o;
				run_next_c = 3'h1;
			end else if (st_valid_i && !st_ready_o) begin
				tx_next    = st_bit_i;
				rdy_next   = 1'b1;
				run_next_c = (st_bit_i == can_tx_o) ? run_reg + 3'h1 : 3'h1;
			end else begin
				// Idle line is recessive and no stuffing outside frames
				tx_next    = 1'b1;
				run_next_c = 3'h0;
			end
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			div_reg    <= 11'h000;
			run_reg    <= 3'h0;
			bit_tick_o <= 1'b0;
			st_ready_o <= 1'b0;
			can_tx_o   <= 1'b1;
		end else begin
			div_reg    <= div_next;
			run_reg    <= run_next_c;
			bit_tick_o <= tick_next;
			st_ready_o <= rdy_next;
			can_tx_o   <= tx_next;
		end
	end
endmodule : gtwo_slave

/* verif/gtwo_slave_props.sv */
/* Checker for the group 2 slave, bound to every gtwo_slave.
   Assumes rate_sel_i changes only under reset. */
`timescale 1ns/100ps
module gtwo_slave_props
	import gtwo_pkg::*;
(
	input wire logic        core_clk_i,
	input wire logic        srst_i,
	input wire logic [5:0]  mac_id_i,
	input wire logic [1:0]  rate_sel_i,
	input wire logic        req_valid_i,
	input wire logic [7:0]  req_service_i,
	input wire logic [7:0]  req_choice_i,
	input wire logic        rsp_valid_o,
	input wire logic [10:0] rsp_id_o,
	input wire logic [31:0] rsp_data_o,
	input wire logic [7:0]  alloc_o,
	input wire logic        rx_cos_valid_i,
	input wire logic [15:0] rx_cos_len_i,
	input wire logic        idle_evt_o,
	input wire logic        run_evt_o,
	input wire logic        tx_valid_o,
	input wire logic        tx_ready_i,
	input wire logic [63:0] tx_data_o,
	input wire logic [7:0]  tx_inst_o,
	input wire logic        bit_tick_o,
	input wire logic        st_valid_i,
	input wire logic        st_ready_o,
	input wire logic        can_tx_o
);
	logic [10:0] gap_reg, gap_next, div;
	logic [2:0]  run_reg, run_next;
	logic        last_reg, last_next, seen_reg, seen_next, svc_ok, cos_on;

	always_comb begin
		div = (rate_sel_i == RATE_SEL_125K) ? DIV_125K :
			(rate_sel_i == RATE_SEL_250K) ? DIV_250K : DIV_500K;
		svc_ok = req_service_i == SVC_ALLOCATE || req_service_i == SVC_RELEASE;
		cos_on = alloc_o[CHOICE_COS_BIT] || alloc_o[CHOICE_CYC_BIT];
		gap_next = bit_tick_o ? 11'h000 : gap_reg + 11'h001;
		seen_next = seen_reg || bit_tick_o;
		last_next = bit_tick_o ? can_tx_o : last_reg;
		run_next = run_reg;
		// Idle line is never stuffed, so runs count inside a stream only
		if (bit_tick_o)
			run_next = !st_valid_i ? 3'h0 :
				(can_tx_o == last_reg && run_reg != 3'h0) ? run_reg + 3'h1 : 3'h1;
	end

	always_ff @(posedge core_clk_i) begin
		{gap_reg, run_reg, last_reg, seen_reg} <= srst_i ? {11'h000, 3'h0, 2'h2} :
			{gap_next, run_next, last_next, seen_next};
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	chk_rsp_ident: assert property (rsp_valid_o |->
		rsp_id_o == {GROUP2_TAG, mac_id_i, MSG_ID_UNCONN}) else $error("bad response id");
	chk_err_code: assert property (req_valid_i && !svc_ok |=> rsp_valid_o &&
		rsp_data_o[31:8] == {ADD_ERR_CODE, GEN_ERR_CODE, SVC_ERROR_RSP}) else $error("bad error");
	chk_alloc_set: assert property (req_valid_i && req_service_i == SVC_ALLOCATE |=>
		(alloc_o & $past(req_choice_i)) == $past(req_choice_i)) else $error("bad allocate");
	chk_cos_event: assert property (rx_cos_valid_i && cos_on |=>
		idle_evt_o == ($past(rx_cos_len_i) == 16'h0000) && run_evt_o != idle_evt_o)
		else $error("bad idle or run event");
	chk_tx_inst: assert property (tx_valid_o |-> tx_inst_o == CONN_INST_COS)
		else $error("bad instance");
	chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o &&
		$stable(tx_data_o)) else $error("frame dropped while stalled");
	chk_bit_period: assert property (bit_tick_o && seen_reg |-> gap_reg == div - 11'h001)
		else $error("bad bit time");
	chk_stuff_bit: assert property (bit_tick_o && st_valid_i && run_reg == 3'h5 |->
		can_tx_o != last_reg && !st_ready_o) else $error("missing stuff bit");
endmodule : gtwo_slave_props

bind gtwo_slave gtwo_slave_props gtwo_slave_props_inst (.core_clk_i, .srst_i, .mac_id_i,
	.rate_sel_i, .req_valid_i, .req_service_i, .req_choice_i, .rsp_valid_o, .rsp_id_o,
	.rsp_data_o, .alloc_o, .rx_cos_valid_i, .rx_cos_len_i, .idle_evt_o, .run_evt_o,
	.tx_valid_o, .tx_ready_i, .tx_data_o, .tx_inst_o, .bit_tick_o, .st_valid_i, .st_ready_o,
	.can_tx_o);

/* verif/gtwo_master_model.sv */
/* Master model: takes slave frames, may stall, acknowledges messages.
   Assumes a frame under eight bytes ends a message. */
`timescale 1ns/100ps
module gtwo_master_model
	import gtwo_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        srst_i,
	input  wire logic        slow_i,
	input  wire logic        acked_i,
	input  wire logic        tx_valid_i,
	input  wire logic [63:0] tx_data_i,
	input  wire logic [3:0]  tx_len_i,
	output logic             tx_ready_o,
	output logic             ack_valid_o
);
	logic [67:0] frames[$];
	logic [1:0]  slot_reg;
	logic [2:0]  dly_reg;
	int          nodata = 0;

	always @(posedge core_clk_i) begin
		if (srst_i) begin
			{slot_reg, dly_reg, tx_ready_o, ack_valid_o} <= 7'h00;
		end else begin
			slot_reg <= slot_reg + 2'h1;
			// Slow mode offers one slot in four
			tx_ready_o <= !slow_i || slot_reg == 2'h3;
			ack_valid_o <= dly_reg == 3'h1;
			dly_reg <= (dly_reg != 3'h0) ? dly_reg - 3'h1 : 3'h0;
			if (tx_valid_i && tx_ready_o) begin
				frames.push_back({tx_len_i, tx_data_i});
				// Empty frame on a data connection means no valid data
				if (tx_len_i == 4'h0)
					nodata <= nodata + 1;
				if (acked_i && tx_len_i < FRAME_BYTES)
					dly_reg <= 3'h4;
			end
		end
	end
endmodule : gtwo_master_model

/* verif/gtwo_slave_tb.sv */
/* Bench for the group 2 slave with a reference kept in queues.
   Assumes the master model in front of the frame port. */
`timescale 1ns/100ps
module gtwo_slave_tb;
	import gtwo_pkg::*;
	logic        core_clk_i = 1'h0, srst_i = 1'h1, slow = 1'h0, acked = 1'h0;
	logic        app_last_i = 1'h0, app_valid_i = 1'h0, change_i = 1'h0, req_valid_i = 1'h0;
	logic        rx_cos_valid_i = 1'h0, st_bit_i = 1'h0, st_valid_i = 1'h0;
	logic [7:0]  app_data_i = 8'h00, req_hdr_i = 8'h00, req_service_i = 8'h00;
	logic [7:0]  req_choice_i = 8'h00, alloc_o, tx_inst_o, q[$];
	logic [5:0]  mac_id_i = 6'h00;
	logic [15:0] rx_cos_len_i = 16'h0000;
	logic        app_ready_o, rsp_valid_o, idle_evt_o, run_evt_o, tx_valid_o, tx_ready_i;
	logic        ack_valid_i, bit_tick_o, st_ready_o, can_tx_o;
	logic [10:0] rsp_id_o;
	logic [31:0] rsp_data_o;
	logic [2:0]  rsp_len_o;
	logic [63:0] tx_data_o;
	logic [3:0]  tx_len_o;
	logic [67:0] ef[$];
	int          am = 0, bad_count = 0, cmp_count = 0, st_idx = 0, bgap = -1, bper = 0;
	logic [2:0]  brun = 3'h0;
	logic [1:0]  rate = 2'h2;
	logic        bl = 1'h1, be = 1'h1;

	gtwo_slave #(.TRIG_CYCLES(3000)) gtwo_slave_inst (.core_clk_i, .srst_i, .mac_id_i,
		.rate_sel_i(rate), .app_data_i, .app_last_i, .app_valid_i, .app_ready_o, .change_i,
		.req_valid_i, .req_hdr_i, .req_service_i, .req_choice_i, .rsp_valid_o, .rsp_id_o,
		.rsp_data_o, .rsp_len_o, .alloc_o, .ack_valid_i, .rx_cos_valid_i, .rx_cos_len_i,
		.idle_evt_o, .run_evt_o, .tx_valid_o, .tx_ready_i, .tx_data_o, .tx_len_o, .tx_inst_o,
		.bit_tick_o, .st_bit_i, .st_valid_i, .st_ready_o, .can_tx_o);
	gtwo_master_model gtwo_master_model_inst (.core_clk_i, .srst_i, .slow_i(slow),
		.acked_i(acked), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_len_i(tx_len_o),
		.tx_ready_o(tx_ready_i), .ack_valid_o(ack_valid_i));

	always #2.5 core_clk_i = ~core_clk_i;

	// Runs of eight equal bits force stuffing in both polarities
	// Line model: stuff after five equal bits, one bit per bit time
	always @(posedge core_clk_i) begin
		#1;
		if (bgap >= 0)
			bgap++;
		if (srst_i) begin
			brun = 3'h0;
			bl   = 1'h1;
			bgap = -1;
		end else if (bit_tick_o === 1'h1) begin
			bper = (rate == RATE_SEL_125K) ? CLK_HZ / RATE_125K_BPS : (rate == RATE_SEL_250K) ?
				CLK_HZ / RATE_250K_BPS : CLK_HZ / RATE_500K_BPS;
			be = (brun == 3'h5) ? !bl : st_bit_i;
			cmp("line_bit", {be, brun != 3'h5}, {can_tx_o, st_ready_o});
			if (bgap >= 0)
				cmp("bit_time", bper, bgap);
			brun = (brun != 3'h5 && brun != 3'h0 && be == bl) ? brun + 3'h1 : 3'h1;
			bl   = be;
			bgap = 0;
		end
		if (st_ready_o === 1'h1) begin
			st_idx++;
			st_bit_i = st_idx[3];
		end
	end

	task automatic cmp(input string n, input logic [67:0] e, input logic [67:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : cmp

	task automatic test_done();
		if (bad_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	task automatic tick();
		@(posedge core_clk_i);
		#1;
	endtask : tick

	task automatic req(input logic [7:0] s, input logic [7:0] c);
		logic [31:0] d;
		logic [2:0]  l;
		{req_valid_i, req_service_i, req_choice_i, req_hdr_i} = {1'h1, s, c, 8'($urandom)};
		d = {ADD_ERR_CODE, GEN_ERR_CODE, SVC_ERROR_RSP, req_hdr_i};
		l = 3'h4;
		if (s == SVC_ALLOCATE || s == SVC_RELEASE) begin
			am = (s == SVC_ALLOCATE) ? am | c : am & ~c;
			d = {16'h0000, s | SVC_RSP_FLAG, req_hdr_i};
			l = (s == SVC_ALLOCATE) ? 3'h3 : 3'h2;
		end
		tick();
		cmp("rsp", {1'h1, l, d}, {rsp_valid_o, rsp_len_o, rsp_data_o});
		cmp("rsp_id", {GROUP2_TAG, mac_id_i, MSG_ID_UNCONN}, rsp_id_o);
		cmp("alloc", 8'(am), alloc_o);
	endtask : req

	task automatic cos(input logic [15:0] n);
		{rx_cos_valid_i, rx_cos_len_i} = {1'h1, n};
		tick();
		cmp("evt", (am & 8'h30) == 0 ? 2'h0 : {n == 16'h0000, n != 16'h0000},
			{idle_evt_o, run_evt_o});
	endtask : cos

	task automatic push(input int n);
		logic r;
		for (int i = 0; i < n; i++) begin
			{app_valid_i, app_data_i, app_last_i} = {1'h1, 8'($urandom), i == n - 1};
			do begin
				r = app_ready_o;
				tick();
			end while (r !== 1'h1);
			q.push_back(app_data_i);
		end
		app_valid_i = 1'h0;
	endtask : push

	task automatic trig();
		change_i = 1'h1;
		tick();
		change_i = 1'h0;
	endtask : trig

	task automatic expect_msg();
		int          n, k;
		logic [63:0] d;
		logic [67:0] f;
		n = q.size();
		for (int c = 0; c == 0 || c * 7 < n; c++) begin
			k = (n <= 8) ? n : (n - c * 7 > 7) ? 7 : n - c * 7;
			d = 64'h0;
			if (n > 8)
				d[7:0] = {(c == 0) ? FRAG_FIRST : (c * 7 + k == n) ? FRAG_LAST : FRAG_MIDDLE, 6'(c)};
			for (int i = 0; i < k; i++)
				d[8 * (i + (n > 8)) +: 8] = q[c * 7 + i];
			ef.push_back({4'(k + (n > 8)), d});
		end
		q.delete();
		for (int i = 0; i < 20000 && gtwo_master_model_inst.frames.size() < ef.size(); i++)
			tick();
		cmp("frames", ef.size(), gtwo_master_model_inst.frames.size());
		while (ef.size() > 0 && gtwo_master_model_inst.frames.size() > 0) begin
			f = gtwo_master_model_inst.frames.pop_front();
			f[63:0] &= (64'h1 << (8 * f[67:64])) - 64'h1;
			cmp("frame", ef.pop_front(), f);
		end
		ef.delete();
	endtask : expect_msg

	initial begin
		void'($urandom(32'hD869));
		mac_id_i = 6'($urandom);
		repeat (6) @(posedge core_clk_i);
		#1;
		{srst_i, st_valid_i} = 2'h1;
		req(SVC_ALLOCATE, 8'h02);
		req(SVC_RELEASE, 8'h02);
		for (int i = 0; i < 3; i++)
			req(8'h0E + 8'(i * 2), 8'($urandom));
		req(8'($urandom) | 8'h60, 8'h02);
		req_valid_i = 1'h0;
		cos(16'h0000);
		rx_cos_valid_i = 1'h0;
		push(32);
		repeat (2) tick();
		cmp("full", 1'h0, app_ready_o);
		slow = 1'h1;
		req(SVC_ALLOCATE, 8'h50);
		req_valid_i = 1'h0;
		cos(16'h0000);
		cos(16'h0005);
		rx_cos_valid_i = 1'h0;
		trig();
		expect_msg();
		push(2);
		trig();
		expect_msg();
		{slow, acked} = 2'h1;
		req(SVC_RELEASE, 8'h50);
		req(SVC_ALLOCATE, 8'h10);
		req_valid_i = 1'h0;
		push(3);
		trig();
		expect_msg();
		push(2);
		expect_msg();
		cmp("no_data", 0, gtwo_master_model_inst.nodata);
		// Rate only changes under reset, so each slower rate gets a fresh reset
		for (int r = 0; r < 2; r++) begin
			srst_i = 1'h1;
			rate   = (r == 0) ? RATE_SEL_125K : RATE_SEL_250K;
			repeat (2) tick();
			srst_i = 1'h0;
			repeat (5 * CLK_HZ / RATE_125K_BPS) tick();
		end
		test_done();
	end

	initial begin
		#200000;
		bad_count++;
		test_done();
	end
endmodule : gtwo_slave_tb
